// file: rtl/exvm_params.svh
// constants for the exception vector selector and address map
`ifndef EXVM_PARAMS_SVH
`define EXVM_PARAMS_SVH
`define EXVM_VEC_RESET      24'h000000
`define EXVM_VEC_ZERODIV    24'h000002
`define EXVM_VEC_WDT        24'h000004
`define EXVM_VEC_KEY7       24'h000006
`define EXVM_VEC_TMR0       24'h000016
`define EXVM_VEC_RSV0       24'h000026
`define EXVM_VEC_SER0       24'h000028
`define EXVM_VEC_SWT        24'h00002E
`define EXVM_VEC_CLKT       24'h000034
`define EXVM_VEC_TMR4       24'h00003C
`define EXVM_VEC_SER1       24'h00004C
`define EXVM_VEC_LAST       24'h000051
`define EXVM_VEC_RSV1       24'h000052
`define EXVM_SWI_LO         24'h000054
`define EXVM_SWI_HI         24'h0000FF
`define EXVM_FL1_LO         24'h000000
`define EXVM_FL1_HI         24'h00BFFF
`define EXVM_FL2_LO         24'h010000
`define EXVM_FL2_HI         24'h03FFFF
`define EXVM_RAM_LO         24'h00D800
`define EXVM_RAM_HI         24'h00F7FF
`define EXVM_IO_LO          24'h00FF00
`define EXVM_IO_HI          24'h00FFFF
`define EXVM_LCD_BLK_LO     4'h8
`define EXVM_LCD_BLK_HI     4'hD
`define EXVM_LCD_OFS_HI     8'h5F
`define EXVM_NSRC           39
`define EXVM_LVLW           2
`endif

// file: rtl/exvm_pkg.sv
// types for the exception vector selector and address map
package exvm_pkg;
    typedef enum logic [2:0] {
        EXVM_REG_NONE,
        EXVM_REG_FLASH1,
        EXVM_REG_FLASH2,
        EXVM_REG_RAM,
        EXVM_REG_IO,
        EXVM_REG_LCD
    } exvm_region_t;
    typedef enum {
        EXVM_IDLE,
        EXVM_PUSH_PCL,
        EXVM_PUSH_PCH,
        EXVM_PUSH_FLAGS,
        EXVM_FETCH_LO,
        EXVM_FETCH_HI,
        EXVM_BRANCH
    } exvm_state_t;
endpackage : exvm_pkg

// file: rtl/exvm_decode.sv
// address region decoder for the core bus
`include "exvm_params.svh"
module exvm_decode (
    input  wire logic [23:0]         addr,
    output exvm_pkg::exvm_region_t   region
);
    always_comb begin
        region = exvm_pkg::EXVM_REG_NONE;
        if (addr <= `EXVM_FL1_HI) begin
            region = exvm_pkg::EXVM_REG_FLASH1;
        end else if (addr >= `EXVM_FL2_LO && addr <= `EXVM_FL2_HI) begin
            region = exvm_pkg::EXVM_REG_FLASH2;
        end else if (addr >= `EXVM_RAM_LO && addr <= `EXVM_RAM_HI) begin
            region = exvm_pkg::EXVM_REG_RAM;
        end else if (addr >= `EXVM_IO_LO && addr <= `EXVM_IO_HI) begin
            region = exvm_pkg::EXVM_REG_IO;
        end else if (addr[23:12] == 12'h00F && addr[11:8] >= `EXVM_LCD_BLK_LO
                     && addr[11:8] <= `EXVM_LCD_BLK_HI && addr[7:0] <= `EXVM_LCD_OFS_HI) begin
            region = exvm_pkg::EXVM_REG_LCD;
        end
    end
endmodule : exvm_decode

// file: rtl/exvm_top.sv
// exception vector selection, entry sequencing and memory map decode
`include "exvm_params.svh"
module exvm_top #(
    parameter int NSRC = `EXVM_NSRC,
    parameter int LVLW = `EXVM_LVLW
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST,
    input  wire logic [NSRC-1:0]        IRQ_PEND,
    input  wire logic [NSRC*LVLW-1:0]   IRQ_LEVEL,
    input  wire logic [LVLW-1:0]        CPU_LEVEL,
    input  wire logic                   SWI_REQ,
    input  wire logic [7:0]             SWI_VEC,
    input  wire logic [15:0]            PC_IN,
    input  wire logic [7:0]             FLAGS_IN,
    input  wire logic [7:0]             VEC_RDATA,
    input  wire logic [23:0]            BUS_ADDR,
    input  wire logic                   BUS_WR,
    input  wire logic [3:0]             BRANCH_COND,
    output logic                        EXC_BUSY,
    output logic                        EXC_ACK,
    output logic [5:0]                  EXC_SRC,
    output logic [23:0]                 VEC_ADDR,
    output logic                        VEC_RD,
    output logic                        STACK_WR,
    output logic [7:0]                  STACK_WDATA,
    output logic                        BRANCH_GO,
    output logic [15:0]                 BRANCH_PC,
    output logic [2:0]                  BUS_REGION,
    output logic                        BUS_WR_EN,
    output logic                        COND_VALID
);
    // ==========================================================
    // source to vector mapping
    // index 0 is zero division; reset is taken by the core itself
    function automatic logic [23:0] exvm_vec_of(input logic [5:0] idx);
        logic [23:0] v;
        v = `EXVM_VEC_ZERODIV;
        if (idx == 6'h00) begin
            v = `EXVM_VEC_ZERODIV;
        end else if (idx == 6'h01) begin
            v = `EXVM_VEC_WDT;
        end else if (idx <= 6'h09) begin
            v = `EXVM_VEC_KEY7 + {17'h0, idx - 6'h02, 1'b0};
        end else if (idx <= 6'h11) begin
            v = `EXVM_VEC_TMR0 + {17'h0, idx - 6'h0A, 1'b0};
        end else if (idx <= 6'h14) begin
            v = `EXVM_VEC_SER0 + {17'h0, idx - 6'h12, 1'b0};
        end else if (idx <= 6'h17) begin
            v = `EXVM_VEC_SWT + {17'h0, idx - 6'h15, 1'b0};
        end else if (idx <= 6'h1B) begin
            v = `EXVM_VEC_CLKT + {17'h0, idx - 6'h18, 1'b0};
        end else if (idx <= 6'h23) begin
            v = `EXVM_VEC_TMR4 + {17'h0, idx - 6'h1C, 1'b0};
        end else begin
            v = `EXVM_VEC_SER1 + {17'h0, idx - 6'h24, 1'b0};
        end
        return v;
    endfunction : exvm_vec_of

    // ==========================================================
    // priority resolve
    // watchdog (index 1), like index 0, is non-maskable and outranks any level; zero division (index 0) wins over it
    logic               win_any;
    logic [5:0]         win_idx;
    logic [LVLW-1:0]    win_lvl;
    always_comb begin
        win_any = 1'b0;
        win_idx = 6'h00;
        win_lvl = '0;
        for (int i = 0; i < NSRC; i++) begin
            logic [LVLW-1:0] lv;
            logic            ok;
            lv = IRQ_LEVEL[i*LVLW +: LVLW];
            ok = IRQ_PEND[i] && (i < 2 || lv > CPU_LEVEL);
            // strict greater keeps the lower vector on equal levels
            if (ok && (!win_any || (i >= 2 && win_idx >= 6'h02 && lv > win_lvl))) begin
                win_any = 1'b1;
                win_idx = 6'(i);
                win_lvl = lv;
            end
        end
    end

    // ==========================================================
    // entry sequencer
    exvm_pkg::exvm_state_t state;
    logic [23:0]           vec;
    logic [15:0]           pc_save;
    logic [7:0]            flags_save;
    logic [7:0]            lo_byte;
    logic                  swi_ok;
    assign swi_ok = SWI_VEC >= `EXVM_SWI_LO && !SWI_VEC[0];

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state <= exvm_pkg::EXVM_IDLE;
        end else begin
            case (state)
                exvm_pkg::EXVM_IDLE: begin
                    if (win_any || (SWI_REQ && swi_ok)) begin
                        state <= exvm_pkg::EXVM_PUSH_PCL;
                    end
                end
                exvm_pkg::EXVM_PUSH_PCL:   state <= exvm_pkg::EXVM_PUSH_PCH;
                exvm_pkg::EXVM_PUSH_PCH:   state <= exvm_pkg::EXVM_PUSH_FLAGS;
                exvm_pkg::EXVM_PUSH_FLAGS: state <= exvm_pkg::EXVM_FETCH_LO;
                exvm_pkg::EXVM_FETCH_LO:   state <= exvm_pkg::EXVM_FETCH_HI;
                exvm_pkg::EXVM_FETCH_HI:   state <= exvm_pkg::EXVM_BRANCH;
                exvm_pkg::EXVM_BRANCH:     state <= exvm_pkg::EXVM_IDLE;
                default:                   state <= exvm_pkg::EXVM_IDLE;
            endcase
        end
    end

    // hardware sources win over a simultaneous software request
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            vec        <= 24'h000000;
            pc_save    <= 16'h0000;
            flags_save <= 8'h00;
            EXC_SRC    <= 6'h00;
        end else if (state == exvm_pkg::EXVM_IDLE && (win_any || (SWI_REQ && swi_ok))) begin
            pc_save    <= PC_IN;
            flags_save <= FLAGS_IN;
            if (win_any) begin
                vec     <= exvm_vec_of(win_idx);
                EXC_SRC <= win_idx;
            end else begin
                vec     <= {16'h0000, SWI_VEC};
                EXC_SRC <= 6'h3F;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            lo_byte <= 8'h00;
        end else if (state == exvm_pkg::EXVM_FETCH_LO) begin
            lo_byte <= VEC_RDATA;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            BRANCH_PC <= 16'h0000;
        end else if (state == exvm_pkg::EXVM_FETCH_HI) begin
            BRANCH_PC <= {VEC_RDATA, lo_byte};
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        STACK_WR    = 1'b0;
        STACK_WDATA = 8'h00;
        VEC_RD      = 1'b0;
        VEC_ADDR    = 24'h000000;
        case (state)
            exvm_pkg::EXVM_PUSH_PCL: begin
                STACK_WR    = 1'b1;
                STACK_WDATA = pc_save[7:0];
            end
            exvm_pkg::EXVM_PUSH_PCH: begin
                STACK_WR    = 1'b1;
                STACK_WDATA = pc_save[15:8];
            end
            exvm_pkg::EXVM_PUSH_FLAGS: begin
                STACK_WR    = 1'b1;
                STACK_WDATA = flags_save;
            end
            exvm_pkg::EXVM_FETCH_LO: begin
                VEC_RD   = 1'b1;
                VEC_ADDR = vec;
            end
            exvm_pkg::EXVM_FETCH_HI: begin
                VEC_RD   = 1'b1;
                VEC_ADDR = vec + 24'h000001;
            end
            default: begin
                VEC_RD = 1'b0;
            end
        endcase
    end

    assign EXC_BUSY  = state != exvm_pkg::EXVM_IDLE;
    assign EXC_ACK   = state == exvm_pkg::EXVM_PUSH_PCL;
    assign BRANCH_GO = state == exvm_pkg::EXVM_BRANCH;

    // ==========================================================
    // address map
    exvm_pkg::exvm_region_t region;
    exvm_decode u_decode (
        .addr   (BUS_ADDR),
        .region (region)
    );
    assign BUS_REGION = region;
    // flash is not writable by plain stores; unmapped writes are dropped
    assign BUS_WR_EN  = BUS_WR && (region == exvm_pkg::EXVM_REG_RAM || region == exvm_pkg::EXVM_REG_IO
                                   || region == exvm_pkg::EXVM_REG_LCD);

    // code 4'hF denotes the custom condition; always rejected
    assign COND_VALID = BRANCH_COND != 4'hF;
endmodule : exvm_top

// file: verification/exvm_cpu_model.sv
// behavioural core model: answers vector fetches and supplies pc and flags
module exvm_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        busy,
    input  wire logic [23:0] vec_addr,
    input  wire logic        vec_rd,
    output logic      [15:0] pc,
    output logic      [7:0]  flags,
    output logic      [7:0]  vec_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // vector table
    // each byte is its address xor 5AH, so a wrong byte order shows in the target
    assign vec_rdata = vec_rd ? vec_addr[7:0] ^ 8'h5A : ~(vec_addr[7:0] ^ 8'h5A);
    assign flags = pc[7:0] ^ 8'h3C;
    // pc moves every cycle while not busy, so a late sample of pc shows in the pushed bytes
    always_ff @(posedge clk) begin
        if (rst) begin
            pc <= 16'h8001;
        end else if (!busy) begin
            pc <= pc + 16'h0103;
        end
    end
endmodule : exvm_cpu_model

// file: verification/exvm_assertions.sv
// checker for the exception vector selector and address map
module exvm_checker (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic [15:0] PC_IN,
    input wire logic [7:0]  FLAGS_IN,
    input wire logic [7:0]  VEC_RDATA,
    input wire logic [23:0] BUS_ADDR,
    input wire logic        BUS_WR,
    input wire logic [3:0]  BRANCH_COND,
    input wire logic        EXC_ACK,
    input wire logic [5:0]  EXC_SRC,
    input wire logic [23:0] VEC_ADDR,
    input wire logic        VEC_RD,
    input wire logic        STACK_WR,
    input wire logic [7:0]  STACK_WDATA,
    input wire logic        BRANCH_GO,
    input wire logic [15:0] BRANCH_PC,
    input wire logic [2:0]  BUS_REGION,
    input wire logic        BUS_WR_EN,
    input wire logic        COND_VALID
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pc_lo;
    logic [7:0] pc_hi;
    assign pc_lo = PC_IN[7:0];
    assign pc_hi = PC_IN[15:8];
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ====
    // entry sequence
    sequence s_push;
        STACK_WR && STACK_WDATA == $past(pc_lo) ##1 STACK_WR && STACK_WDATA == $past(pc_hi, 2)
        ##1 STACK_WR && STACK_WDATA == $past(FLAGS_IN, 3);
    endsequence
    sequence s_fetch;
        VEC_RD ##1 VEC_RD && VEC_ADDR == $past(VEC_ADDR) + 24'h1
        ##1 BRANCH_GO && BRANCH_PC == {$past(VEC_RDATA), $past(VEC_RDATA, 2)};
    endsequence
    a_entry_order: assert property (EXC_ACK |-> s_push ##1 s_fetch)
        else $error("exception entry out of order");
    a_vec_reserved: assert property (VEC_RD |-> VEC_ADDR <= 24'hFF &&
        !(VEC_ADDR inside {24'h26, 24'h27, 24'h52, 24'h53})) else $error("reserved vector fetched");
    a_hw_vector: assert property (BRANCH_GO && EXC_SRC != 6'h3F |->
        $past(VEC_ADDR, 2) inside {[24'h2:24'h50]}) else $error("hardware vector outside table");
    a_soft_vector: assert property (BRANCH_GO && EXC_SRC == 6'h3F |->
        $past(VEC_ADDR, 2) inside {[24'h54:24'hFE]} && $past(VEC_ADDR, 2) % 2 == 0) else $error("bad soft vector");
    a_cond_flag: assert property (COND_VALID == (BRANCH_COND != 4'hF))
        else $error("custom condition accepted");
    a_flash1_map: assert property (BUS_ADDR <= 24'hBFFF |-> BUS_REGION == 3'h1)
        else $error("flash area 1 decode");
    a_flash2_map: assert property (BUS_ADDR inside {[24'h10000:24'h3FFFF]} |-> BUS_REGION == 3'h2)
        else $error("flash area 2 decode");
    a_ram_map: assert property (BUS_ADDR inside {[24'hD800:24'hF7FF]} |-> BUS_REGION == 3'h3)
        else $error("ram decode");
    a_io_map: assert property (BUS_ADDR inside {[24'hFF00:24'hFFFF]} |-> BUS_REGION == 3'h4)
        else $error("io decode");
    a_unmapped_write: assert property (BUS_WR && BUS_REGION == 3'h0 |-> !BUS_WR_EN)
        else $error("unmapped write enabled");
endmodule : exvm_checker

bind exvm_top exvm_checker u_chk (.REF_CLK(REF_CLK), .RST(RST), .PC_IN(PC_IN), .FLAGS_IN(FLAGS_IN),
    .VEC_RDATA(VEC_RDATA), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BRANCH_COND(BRANCH_COND), .EXC_ACK(EXC_ACK),
    .EXC_SRC(EXC_SRC), .VEC_ADDR(VEC_ADDR), .VEC_RD(VEC_RD), .STACK_WR(STACK_WR), .STACK_WDATA(STACK_WDATA),
    .BRANCH_GO(BRANCH_GO), .BRANCH_PC(BRANCH_PC), .BUS_REGION(BUS_REGION), .BUS_WR_EN(BUS_WR_EN),
    .COND_VALID(COND_VALID));

// file: verification/tb_top.sv
// self-checking bench for the exception vector selector and address map
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NS = 39;
    logic            REF_CLK = 1'h0, RST = 1'h1, SWI_REQ = 1'h0, BUS_WR = 1'h1;
    logic [NS-1:0]   IRQ_PEND = '0;
    logic [2*NS-1:0] IRQ_LEVEL = {NS{2'h1}};
    logic [1:0]      CPU_LEVEL = 2'h0;
    logic [7:0]      SWI_VEC = 8'h54, FLAGS_IN, VEC_RDATA, STACK_WDATA;
    logic [15:0]     PC_IN, BRANCH_PC;
    logic [23:0]     BUS_ADDR = 24'h0, VEC_ADDR;
    logic [3:0]      BRANCH_COND = 4'h0;
    logic [5:0]      EXC_SRC;
    logic [2:0]      BUS_REGION;
    logic            EXC_BUSY, EXC_ACK, VEC_RD, STACK_WR, BRANCH_GO, BUS_WR_EN, COND_VALID;
    int              err_count = 0, n_checks = 0;
    initial forever #25 REF_CLK = ~REF_CLK;
    exvm_top #(.NSRC(NS), .LVLW(2)) uut (.REF_CLK(REF_CLK), .RST(RST), .IRQ_PEND(IRQ_PEND),
        .IRQ_LEVEL(IRQ_LEVEL), .CPU_LEVEL(CPU_LEVEL), .SWI_REQ(SWI_REQ), .SWI_VEC(SWI_VEC), .PC_IN(PC_IN),
        .FLAGS_IN(FLAGS_IN), .VEC_RDATA(VEC_RDATA), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
        .BRANCH_COND(BRANCH_COND), .EXC_BUSY(EXC_BUSY), .EXC_ACK(EXC_ACK), .EXC_SRC(EXC_SRC),
        .VEC_ADDR(VEC_ADDR), .VEC_RD(VEC_RD), .STACK_WR(STACK_WR), .STACK_WDATA(STACK_WDATA),
        .BRANCH_GO(BRANCH_GO), .BRANCH_PC(BRANCH_PC), .BUS_REGION(BUS_REGION), .BUS_WR_EN(BUS_WR_EN),
        .COND_VALID(COND_VALID));
    exvm_cpu_model cpu (.clk(REF_CLK), .rst(RST), .busy(EXC_BUSY), .vec_addr(VEC_ADDR), .vec_rd(VEC_RD),
        .pc(PC_IN), .flags(FLAGS_IN), .vec_rdata(VEC_RDATA));
    // ====
    // shared tasks
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // requests are dropped once acknowledged, else a level source is taken again
    task automatic exc(input logic [NS-1:0] pend, input logic swi, input logic [5:0] src, input logic [7:0] vec);
        int          k;
        logic [15:0] pc0;
        logic [7:0]  fl0;
        k = 0;
        pc0 = PC_IN;
        fl0 = FLAGS_IN;
        IRQ_PEND = pend;
        SWI_REQ = swi;
        SWI_VEC = vec;
        while (EXC_ACK !== 1'h1 && k < 6) begin
            @(negedge REF_CLK);
            k++;
        end
        IRQ_PEND = '0;
        SWI_REQ = 1'h0;
        // the pushed bytes stand one cycle each, low pc first, then high pc, then flags
        chk("pushed pc low", STACK_WDATA, pc0[7:0]);
        @(negedge REF_CLK);
        chk("pushed pc high", STACK_WDATA, pc0[15:8]);
        @(negedge REF_CLK);
        chk("pushed flags", STACK_WDATA, fl0);
        k = k + 2;
        while (BRANCH_GO !== 1'h1 && k < 14) begin
            @(negedge REF_CLK);
            k++;
        end
        chk("branch", BRANCH_GO, 1'h1);
        chk("source", EXC_SRC, src);
        chk("target", BRANCH_PC, {vec + 8'h1 ^ 8'h5A, vec ^ 8'h5A});
        @(negedge REF_CLK);
    endtask : exc
    // ====
    // scenarios
    task automatic t_sources;
        for (int i = 0; i < NS; i++) begin
            exc(NS'(1) << i, 1'h0, 6'(i), 8'(i < 18 ? 2 + 2 * i : 4 + 2 * i));
        end
    endtask : t_sources
    task automatic t_priority;
        exc((NS'(1) << 20) | (NS'(1) << 38), 1'h0, 6'h14, 8'h2C);
        exc((NS'(1) << 37) | (NS'(1) << 38), 1'h0, 6'h25, 8'h4E);
        exc(NS'(3), 1'h0, 6'h00, 8'h02);
        IRQ_LEVEL[76 +: 2] = 2'h2;
        exc((NS'(1) << 2) | (NS'(1) << 38), 1'h0, 6'h26, 8'h50);
        IRQ_LEVEL[76 +: 2] = 2'h1;
    endtask : t_priority
    task automatic t_soft;
        exc('0, 1'h1, 6'h3F, 8'h54);
        exc('0, 1'h1, 6'h3F, 8'hFE);
        SWI_VEC = 8'h52;
        SWI_REQ = 1'h1;
        repeat (4) @(negedge REF_CLK);
        chk("busy", EXC_BUSY, 1'h0);
        SWI_REQ = 1'h0;
    endtask : t_soft
    task automatic t_decode;
        logic [23:0] a [16] = '{24'h0, 24'hBFFF, 24'hC000, 24'h10000, 24'h3FFFF, 24'h40000, 24'hD800, 24'hF7FF,
            24'hF800, 24'hF85F, 24'hF860, 24'hFD5F, 24'hFE00, 24'hFF00, 24'hFFFF, 24'hD7FF};
        logic [2:0] r [16] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h3, 3'h3, 3'h5, 3'h5, 3'h0, 3'h5, 3'h0,
            3'h4, 3'h4, 3'h0};
        for (int i = 0; i < 16; i++) begin
            @(negedge REF_CLK);
            BUS_ADDR = a[i];
            #1;
            chk("region", BUS_REGION, r[i]);
            chk("write enable", BUS_WR_EN, r[i] >= 3'h3);
        end
        // a read of a writable region must not raise the write enable
        @(negedge REF_CLK);
        BUS_ADDR = 24'hD800;
        BUS_WR = 1'h0;
        #1;
        chk("read write enable", BUS_WR_EN, 1'h0);
        @(negedge REF_CLK);
        BUS_WR = 1'h1;
    endtask : t_decode
    task automatic t_cond;
        for (int c = 0; c < 16; c++) begin
            @(negedge REF_CLK);
            BRANCH_COND = 4'(c);
            #1;
            chk("cond valid", COND_VALID, c != 15);
        end
    endtask : t_cond
    initial begin
        repeat (8) @(negedge REF_CLK);
        RST = 1'h0;
        @(negedge REF_CLK);
        t_decode();
        t_cond();
        t_sources();
        t_priority();
        t_soft();
        wrap_up();
    end
    // whole run is near 360 cycles; the limit leaves wide margin
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule : tb_top
